/* clock_synth_cfg.svh */
`ifndef CLOCK_SYNTH_CFG_SVH
`define CLOCK_SYNTH_CFG_SVH

// Register offsets (byte addresses)
`define ADDR_PWR        8'h00
`define ADDR_CLKOUT     8'h04
`define ADDR_VCODIV     8'h08
`define ADDR_CARRIER_FREQ_SET_A      8'h0c
`define ADDR_CARRIER_FREQ_SET_B      8'h10
`define ADDR_RNGA       8'h14
`define ADDR_RNGB       8'h18
`define ADDR_LOOPN      8'h1c
`define ADDR_LOOPB      8'h20
`define ADDR_CPN        8'h24
`define ADDR_CPB        8'h28
`define ADDR_BOOST      8'h2c
`define ADDR_SYNTH      8'h30
`define ADDR_LPO        8'h34

// Field positions
`define PWR_XO_BIT      0
`define PWR_RST_BIT     7
`define CLKOUT_SRC_BIT  5
`define CLKOUT_DIS_BIT  6
`define VCODIV_OUTPUT_DIVIDER_BIT    2
`define VCODIV_VCO_SOURCE_SELECT   4
`define VCODIV_INDUCT   5
`define RANGING_START_BIT   4
`define RNG_ERR_BIT     5
`define BOOST_EN_BIT    16
`define SYNTH_EN_BIT    0
`define SYNTH_SELB_BIT  1
`define LPO_FAST_BIT    0
`define LPO_CAL_BIT     1
`define LPO_DONE_BIT    2
`define LPO_TRIM_LSB    8

// Reset values
`define PWR_RST_VAL     1'b1
`define CLKOUT_SEL_RST  5'h04
`define DIV_SEL_MAX     5'h0a
`define VCODIV_RST      6'h00
`define FREQ_RST        32'h00000000
`define LOOPN_RST       2'h1
`define LOOPB_RST       2'h3
`define CPN_RST         8'h10
`define CPB_RST         8'h40
`define BOOST_DUR_RST   16'h0020
`define LPO_TRIM_RST    8'h80
`define RNG_INIT        4'h8
`define RNG_MAX         4'hf

// Timing
`define CLK_HZ          10000000
`define CLK_PERIOD_NS   100
`define LPO_SLOW_HZ     640
`define LPO_FAST_HZ     10200
`define LPO_SLOW_CYC    (`CLK_HZ / `LPO_SLOW_HZ)
`define LPO_FAST_CYC    (`CLK_HZ / `LPO_FAST_HZ)
`define RNG_SETTLE_NS   5000
`define RNG_SETTLE_CYC  ((`RNG_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* clock_synth_pkg.sv */
`default_nettype none
package clock_synth_pkg;
  typedef enum logic [1:0] {
    RNG_IDLE   = 2'b00,
    RNG_TRY    = 2'b01,
    RNG_SETTLE = 2'b10
  } rng_state_t;
  typedef logic [3:0]  vco_range_t;
  typedef logic [31:0] reg_word_t;
endpackage
`default_nettype wire

/* radio_clock_synth_control.sv */
`timescale 1ns/10ps
`default_nettype none
`include "clock_synth_cfg.svh"

// Behaviour
// - Low-power oscillator 640 Hz or 10.2 kHz
// - Background calibration against reference clock
// - Clock pin: divided reference, oscillator, or off
// - Five-bit field, ratios 1 to 1024
// - Divided output has 50% duty
// - After power-up output is reference/16
// - Any reset restores register defaults; soft reset leaves the reset bit set
// - Two 1 Hz-resolution carrier sets A, B
// - Inductor select enables external inductor
// - Inductor 0, source 1: external VCO
// - Start bit readable, cleared when ranging ends
// - Register A ranges set A, B ranges B
// - Ranging error status bit readable
// - No ranging with fully external VCO
// - Filter and pump fields, normal and boost
// - Boost settings first, then normal automatically
// - Filter code 00 bypasses to filter pin
// - Other filter codes raise bandwidth 2x/5x
// - Reference divider field beside output divider
// - Reference oscillator on at power-up
module radio_clock_synth_control #(
  parameter int unsigned CAL_SLOW_CYC = `LPO_SLOW_CYC
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // Register port
  input  wire logic [7:0]                 regAddr,
  input  wire logic [31:0]                regWrData,
  input  wire logic                       regWr,
  input  wire logic                       regRd,
  output logic [31:0]                     regRdData,
  // Low-power oscillator
  input  wire logic                       lpoClkIn,
  output logic                            lpoFast,
  output logic [7:0]                      lpoTrim,
  // Clock output pin
  output logic                            sysClkOut,
  output logic                            sysClkOe,
  // Reference oscillator
  output logic                            refOscEnable,
  // Synthesizer control
  input  wire logic                       vcoAboveTarget,
  output logic [31:0]                     carrierFreq,
  output logic [1:0]                      refDivider,
  output logic                            outputDividerBit,
  output logic                            vcoSourceSelect,
  output logic                            inductorSelect,
  output clock_synth_pkg::vco_range_t     vcoRange,
  output logic [1:0]                      loopFilterSelect,
  output logic [7:0]                      chargePumpCurrent,
  output logic                            externalFilterBypass,
  output logic                            boostActive
);
  import clock_synth_pkg::*;

  localparam logic [15:0] CAL_SLOW = 16'(CAL_SLOW_CYC);
  localparam logic [15:0] CAL_FAST = 16'(`LPO_FAST_CYC);
  localparam logic [9:0]  SETTLE   = 10'(`RNG_SETTLE_CYC);

  function automatic logic divTap(input logic [9:0] cnt, input logic [4:0] sel);
    logic [3:0] idx;
    idx = 4'(sel - 5'h01);
    divTap = cnt[idx];
  endfunction

  // Register state
  logic       pwrRst_q;
  logic       xoEn_q;
  logic [4:0] clkSel_q;
  logic       clkSrc_q;
  logic       clkDis_q;
  logic [5:0] vcoDiv_q;
  logic [31:0] carrier_freq_set_a_q;
  logic [31:0] carrier_freq_set_b_q;
  logic [1:0] loopN_q;
  logic [1:0] loopB_q;
  logic [7:0] cpN_q;
  logic [7:0] cpB_q;
  logic       boostEn_q;
  logic [15:0] boostDur_q;
  logic       synthEn_q;
  logic       synthSelB_q;
  logic       lpoFast_q;
  logic       calEn_q;
  logic       calDone_q;
  logic [7:0] trim_q;
  logic       startA_q;
  logic       startB_q;
  logic       errA_q;
  logic       errB_q;
  vco_range_t rangeA_q;
  vco_range_t rangeB_q;
  logic       regRst;
  logic       wrHit;

  assign regRst = rst | pwrRst_q;
  assign wrHit  = regWr;

  // Reset bit itself only cleared by pin reset or a host write
  always_ff @(posedge clk) begin
    if (rst) begin
      pwrRst_q <= 1'b0;
    end else if (wrHit && regAddr == `ADDR_PWR) begin
      pwrRst_q <= regWrData[`PWR_RST_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (regRst) begin
      xoEn_q      <= `PWR_RST_VAL;
      clkSel_q    <= `CLKOUT_SEL_RST;
      clkSrc_q    <= 1'b0;
      clkDis_q    <= 1'b0;
      vcoDiv_q    <= `VCODIV_RST;
      carrier_freq_set_a_q     <= `FREQ_RST;
      carrier_freq_set_b_q     <= `FREQ_RST;
      loopN_q     <= `LOOPN_RST;
      loopB_q     <= `LOOPB_RST;
      cpN_q       <= `CPN_RST;
      cpB_q       <= `CPB_RST;
      boostEn_q   <= 1'b0;
      boostDur_q  <= `BOOST_DUR_RST;
      synthEn_q   <= 1'b0;
      synthSelB_q <= 1'b0;
      lpoFast_q   <= 1'b0;
      calEn_q     <= 1'b0;
    end else if (wrHit) begin
      case (regAddr)
        `ADDR_PWR:    xoEn_q <= regWrData[`PWR_XO_BIT];
        `ADDR_CLKOUT: begin
          clkSel_q <= (regWrData[4:0] > `DIV_SEL_MAX) ? `DIV_SEL_MAX : regWrData[4:0];
          clkSrc_q <= regWrData[`CLKOUT_SRC_BIT];
          clkDis_q <= regWrData[`CLKOUT_DIS_BIT];
        end
        `ADDR_VCODIV: vcoDiv_q <= regWrData[5:0];
        `ADDR_CARRIER_FREQ_SET_A:  carrier_freq_set_a_q <= regWrData;
        `ADDR_CARRIER_FREQ_SET_B:  carrier_freq_set_b_q <= regWrData;
        `ADDR_LOOPN:  loopN_q <= regWrData[1:0];
        `ADDR_LOOPB:  loopB_q <= regWrData[1:0];
        `ADDR_CPN:    cpN_q <= regWrData[7:0];
        `ADDR_CPB:    cpB_q <= regWrData[7:0];
        `ADDR_BOOST: begin
          boostEn_q  <= regWrData[`BOOST_EN_BIT];
          boostDur_q <= regWrData[15:0];
        end
        `ADDR_SYNTH: begin
          synthEn_q   <= regWrData[`SYNTH_EN_BIT];
          synthSelB_q <= regWrData[`SYNTH_SELB_BIT];
        end
        `ADDR_LPO: begin
          lpoFast_q <= regWrData[`LPO_FAST_BIT];
          calEn_q   <= regWrData[`LPO_CAL_BIT];
        end
        default: ;
      endcase
    end
  end

  // Pin synchronisers
  logic lpoS1_q;
  logic lpoS2_q;
  logic lpoS3_q;
  logic vcoS1_q;
  logic vcoS2_q;

  always_ff @(posedge clk) begin
    lpoS1_q <= lpoClkIn;
    lpoS2_q <= lpoS1_q;
    lpoS3_q <= lpoS2_q;
    vcoS1_q <= vcoAboveTarget;
    vcoS2_q <= vcoS1_q;
  end

  // Oscillator calibration: ref cycles per oscillator period vs target
  logic [15:0] calCnt_q;
  logic        calArmed_q;
  logic        lpoRise;
  logic [15:0] calTarget;

  assign lpoRise   = lpoS2_q & ~lpoS3_q;
  assign calTarget = lpoFast_q ? CAL_FAST : CAL_SLOW;

  always_ff @(posedge clk) begin
    if (regRst || !calEn_q) begin
      calCnt_q   <= 16'h0000;
      calArmed_q <= 1'b0;
    end else if (lpoRise) begin
      calCnt_q   <= 16'h0001;
      calArmed_q <= 1'b1;
    end else if (calCnt_q != 16'hffff) begin
      calCnt_q <= calCnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (regRst) begin
      trim_q    <= `LPO_TRIM_RST;
      calDone_q <= 1'b0;
    end else if (calEn_q && calArmed_q && lpoRise) begin
      if (calCnt_q > calTarget && trim_q != 8'hff) begin
        trim_q <= trim_q + 8'h01;
      end else if (calCnt_q < calTarget && trim_q != 8'h00) begin
        trim_q <= trim_q - 8'h01;
      end
      calDone_q <= (calCnt_q == calTarget) | calDone_q;
    end
  end

  // Clock output divider; config swapped only at wrap, with oscillator low when it is the old or new source
  logic [9:0] divCnt_q;
  logic [4:0] actSel_q;
  logic       actSrc_q;
  logic       actDis_q;

  always_ff @(posedge clk) begin
    if (regRst) begin
      divCnt_q <= 10'h000;
    end else begin
      divCnt_q <= divCnt_q + 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (regRst) begin
      actSel_q <= `CLKOUT_SEL_RST;
      actSrc_q <= 1'b0;
      actDis_q <= 1'b0;
    // Oscillator low only matters when it is the old or new source
    end else if (divCnt_q == 10'h3ff && (!lpoS2_q || (!clkSrc_q && !actSrc_q))) begin
      actSel_q <= clkSel_q;
      actSrc_q <= clkSrc_q;
      actDis_q <= clkDis_q;
    end
  end

  always_comb begin
    if (actDis_q) begin
      sysClkOut = 1'b0;
    end else if (actSrc_q) begin
      sysClkOut = lpoS2_q;
    end else if (actSel_q == 5'h00) begin
      sysClkOut = clk;
    end else begin
      sysClkOut = divTap(divCnt_q, actSel_q);
    end
  end
  assign sysClkOe = ~actDis_q;

  // VCO auto-ranging, binary search per frequency set
  rng_state_t rngState_q;
  logic       rngSetB_q;
  logic [1:0] rngBit_q;
  logic [9:0] settleCnt_q;
  vco_range_t trial_q;
  logic       extVco;
  logic       startWrA;
  logic       startWrB;

  assign extVco   = ~vcoDiv_q[`VCODIV_INDUCT] & vcoDiv_q[`VCODIV_VCO_SOURCE_SELECT];
  assign startWrA = wrHit && regAddr == `ADDR_RNGA && regWrData[`RANGING_START_BIT];
  assign startWrB = wrHit && regAddr == `ADDR_RNGB && regWrData[`RANGING_START_BIT];

  always_ff @(posedge clk) begin
    if (regRst) begin
      rngState_q  <= RNG_IDLE;
      rngSetB_q   <= 1'b0;
      rngBit_q    <= 2'h3;
      settleCnt_q <= 10'h000;
      trial_q     <= `RNG_INIT;
      startA_q    <= 1'b0;
      startB_q    <= 1'b0;
      errA_q      <= 1'b0;
      errB_q      <= 1'b0;
      rangeA_q    <= `RNG_INIT;
      rangeB_q    <= `RNG_INIT;
    end else begin
      case (rngState_q)
        RNG_IDLE: begin
          if (startWrA || startWrB) begin
            rngSetB_q <= startWrB & ~startWrA;
            if (extVco) begin
              if (startWrA) errA_q <= 1'b1;
              else errB_q <= 1'b1;
            end else begin
              if (startWrA) begin
                startA_q <= 1'b1;
                errA_q   <= 1'b0;
              end else begin
                startB_q <= 1'b1;
                errB_q   <= 1'b0;
              end
              rngBit_q    <= 2'h3;
              trial_q     <= `RNG_INIT;
              settleCnt_q <= SETTLE;
              rngState_q  <= RNG_SETTLE;
            end
          end
        end
        RNG_SETTLE: begin
          if (settleCnt_q != 10'h000) begin
            settleCnt_q <= settleCnt_q - 10'h001;
          end else begin
            rngState_q <= RNG_TRY;
          end
        end
        RNG_TRY: begin
          if (vcoS2_q) begin
            trial_q[rngBit_q] <= 1'b0;
          end
          if (rngBit_q != 2'h0) begin
            trial_q[rngBit_q - 2'h1] <= 1'b1;
            rngBit_q    <= rngBit_q - 2'h1;
            settleCnt_q <= SETTLE;
            rngState_q  <= RNG_SETTLE;
          end else begin
            rngState_q <= RNG_IDLE;
            if (rngSetB_q) begin
              rangeB_q <= {trial_q[3:1], trial_q[0] & ~vcoS2_q};
              startB_q <= 1'b0;
              errB_q   <= (trial_q == `RNG_MAX) & ~vcoS2_q;
            end else begin
              rangeA_q <= {trial_q[3:1], trial_q[0] & ~vcoS2_q};
              startA_q <= 1'b0;
              errA_q   <= (trial_q == `RNG_MAX) & ~vcoS2_q;
            end
          end
        end
        default: rngState_q <= RNG_IDLE;
      endcase
    end
  end

  // Boost timer from synthesizer enable
  logic        synthEnD_q;
  logic [15:0] boostCnt_q;
  logic        boost_q;

  always_ff @(posedge clk) begin
    if (regRst) begin
      synthEnD_q <= 1'b0;
      boostCnt_q <= 16'h0000;
      boost_q    <= 1'b0;
    end else begin
      synthEnD_q <= synthEn_q;
      if (!synthEn_q) begin
        boost_q <= 1'b0;
      end else if (!synthEnD_q) begin
        boost_q    <= boostEn_q && boostDur_q != 16'h0000;
        boostCnt_q <= boostDur_q;
      end else if (boost_q) begin
        if (boostCnt_q == 16'h0001) boost_q <= 1'b0;
        boostCnt_q <= boostCnt_q - 16'h0001;
      end
    end
  end

  // Registered synthesizer outputs
  always_ff @(posedge clk) begin
    if (regRst) begin
      carrierFreq       <= `FREQ_RST;
      loopFilterSelect  <= `LOOPN_RST;
      chargePumpCurrent <= `CPN_RST;
      vcoRange          <= `RNG_INIT;
    end else begin
      if (rngState_q != RNG_IDLE) begin
        carrierFreq <= rngSetB_q ? carrier_freq_set_b_q : carrier_freq_set_a_q;
        vcoRange    <= trial_q;
      end else begin
        carrierFreq <= synthSelB_q ? carrier_freq_set_b_q : carrier_freq_set_a_q;
        vcoRange    <= synthSelB_q ? rangeB_q : rangeA_q;
      end
      loopFilterSelect  <= boost_q ? loopB_q : loopN_q;
      chargePumpCurrent <= boost_q ? cpB_q : cpN_q;
    end
  end

  assign externalFilterBypass = loopFilterSelect == 2'h0;
  assign boostActive          = boost_q;
  assign refOscEnable         = xoEn_q;
  assign lpoFast              = lpoFast_q;
  assign lpoTrim              = trim_q;
  assign refDivider           = vcoDiv_q[1:0];
  assign outputDividerBit     = vcoDiv_q[`VCODIV_OUTPUT_DIVIDER_BIT];
  assign vcoSourceSelect      = vcoDiv_q[`VCODIV_VCO_SOURCE_SELECT];
  assign inductorSelect       = vcoDiv_q[`VCODIV_INDUCT];

  // Read port, data one cycle after strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdData <= 32'h00000000;
    end else if (regRd) begin
      case (regAddr)
        `ADDR_PWR:    regRdData <= {24'h000000, pwrRst_q, 6'h00, xoEn_q};
        `ADDR_CLKOUT: regRdData <= {25'h0000000, clkDis_q, clkSrc_q, clkSel_q};
        `ADDR_VCODIV: regRdData <= {26'h0000000, vcoDiv_q};
        `ADDR_CARRIER_FREQ_SET_A:  regRdData <= carrier_freq_set_a_q;
        `ADDR_CARRIER_FREQ_SET_B:  regRdData <= carrier_freq_set_b_q;
        `ADDR_RNGA:   regRdData <= {26'h0000000, errA_q, startA_q, rangeA_q};
        `ADDR_RNGB:   regRdData <= {26'h0000000, errB_q, startB_q, rangeB_q};
        `ADDR_LOOPN:  regRdData <= {30'h00000000, loopN_q};
        `ADDR_LOOPB:  regRdData <= {30'h00000000, loopB_q};
        `ADDR_CPN:    regRdData <= {24'h000000, cpN_q};
        `ADDR_CPB:    regRdData <= {24'h000000, cpB_q};
        `ADDR_BOOST:  regRdData <= {15'h0000, boostEn_q, boostDur_q};
        `ADDR_SYNTH:  regRdData <= {29'h00000000, boost_q, synthSelB_q, synthEn_q};
        `ADDR_LPO:    regRdData <= {16'h0000, trim_q, 5'h00, calDone_q, calEn_q, lpoFast_q};
        default:      regRdData <= 32'h00000000;
      endcase
    end else begin
      regRdData <= 32'h00000000;
    end
  end
endmodule

`default_nettype wire

/* radio_clock_synth_control_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module radio_clock_synth_control_properties (
  // Clock and reset
  input wire logic                        clk,
  input wire logic                        rst,
  // Observed ports
  input wire logic                        regRd,
  input wire logic [31:0]                 regRdData,
  input wire logic [7:0]                  lpoTrim,
  input wire logic                        sysClkOe,
  input wire logic                        refOscEnable,
  input wire logic                        vcoSourceSelect,
  input wire logic                        inductorSelect,
  input wire clock_synth_pkg::vco_range_t vcoRange,
  input wire logic [1:0]                  loopFilterSelect,
  input wire logic [7:0]                  chargePumpCurrent,
  input wire logic                        externalFilterBypass,
  input wire logic                        boostActive
);
  import clock_synth_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_bypass_code: assert property (externalFilterBypass == (loopFilterSelect == 2'h0))
    else $error("bypass flag disagrees with filter code");
  a_reset_defaults: assert property ($fell(rst) |-> sysClkOe && refOscEnable && vcoRange == 4'h8
    && lpoTrim == 8'h80 && loopFilterSelect == 2'h1 && chargePumpCurrent == 8'h10)
    else $error("outputs not at defaults after reset");
  a_boost_first: assert property ($rose(boostActive) |=> loopFilterSelect == 2'h3 && chargePumpCurrent == 8'h40)
    else $error("boost settings not applied");
  a_boost_bounded: assert property ($rose(boostActive) |-> ##[1:1000] !boostActive)
    else $error("boost never ends");
  a_normal_after: assert property ($fell(boostActive) |-> ##[1:2] chargePumpCurrent == 8'h10)
    else $error("normal pump current not restored");
  a_range_hold: assert property ($changed(vcoRange) |=> $stable(vcoRange) [*8])
    else $error("range trial not held while settling");
  a_ext_no_range: assert property (vcoSourceSelect && !inductorSelect && $past(vcoSourceSelect)
    && !$past(inductorSelect) |-> $stable(vcoRange))
    else $error("range moved with external VCO");
  a_read_quiet: assert property (!$past(regRd) |-> regRdData == 32'h0)
    else $error("read data outside read slot");
  a_trim_step: assert property ($changed(lpoTrim) |-> lpoTrim == $past(lpoTrim) + 8'h01
    || lpoTrim == $past(lpoTrim) - 8'h01)
    else $error("trim jumped by more than one");

  c_boost: cover property ($rose(boostActive));
  c_range: cover property ($changed(vcoRange));
  c_bypass: cover property (externalFilterBypass);
endmodule
`default_nettype wire

/* radio_far_side_model.sv */
`timescale 1ns/10ps
`default_nettype none
module radio_far_side_model #(
  parameter int SLOW_CYC = 200,
  parameter int FAST_CYC = 980,
  parameter int TARGET   = 5
) (
  // Clock
  input  wire logic                        clk,
  // Low-power oscillator
  input  wire logic                        lpoFast,
  input  wire logic [7:0]                  lpoTrim,
  output logic                             lpoClkIn,
  // VCO comparator
  input  wire clock_synth_pkg::vco_range_t vcoRange,
  output logic                             vcoAboveTarget
);
  import clock_synth_pkg::*;
  int period;
  int phase;
  // Higher trim shortens the period; nominal at trim 0x86
  assign period = (lpoFast ? FAST_CYC : SLOW_CYC) + 134 - int'(lpoTrim);
  initial begin
    phase = 0;
    lpoClkIn = 1'b0;
    vcoAboveTarget = 1'b0;
  end
  always @(posedge clk) begin
    phase <= (phase + 1 >= period) ? 0 : phase + 1;
    lpoClkIn <= (phase < period / 2);
    vcoAboveTarget <= (int'(vcoRange) > TARGET);
  end
endmodule
`default_nettype wire

/* radio_clock_synth_control_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "clock_synth_cfg.svh"
module radio_clock_synth_control_tb;
  import clock_synth_pkg::*;
  localparam logic [31:0] Carrier_freq_set_a = 32'h1b3a_0001;
  localparam logic [31:0] Carrier_freq_set_b = 32'h1b3a_0002;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [31:0] regRdData, carrierFreq, d;
  logic [7:0]  lpoTrim, chargePumpCurrent;
  logic [1:0]  refDivider, loopFilterSelect;
  logic        lpoClkIn, lpoFast, sysClkOut, sysClkOe, refOscEnable, vcoAboveTarget;
  logic        outputDividerBit, vcoSourceSelect, inductorSelect, externalFilterBypass, boostActive;
  vco_range_t  vcoRange;
  int          n_fail = 0;
  int          n_checks = 0;
  int          hi, lo, n;
  logic [7:0]  dAddr [11] = '{`ADDR_PWR, `ADDR_CLKOUT, `ADDR_VCODIV, `ADDR_LOOPN, `ADDR_LOOPB, `ADDR_CPN,
                              `ADDR_CPB, `ADDR_BOOST, `ADDR_LPO, `ADDR_CARRIER_FREQ_SET_A, 8'hfc};
  logic [31:0] dVal [11] = '{32'h1, 32'h4, 32'h0, 32'h1, 32'h3, 32'h10, 32'h40, 32'h20, 32'h8000, 32'h0, 32'h0};
  logic [4:0]  sel [3] = '{5'h03, 5'h0a, 5'h1f};
  int          half [3] = '{4, 512, 512};

  radio_clock_synth_control #(.CAL_SLOW_CYC(200)) i_dut (.clk, .rst, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .lpoClkIn, .lpoFast, .lpoTrim, .sysClkOut, .sysClkOe, .refOscEnable, .vcoAboveTarget,
    .carrierFreq, .refDivider, .outputDividerBit, .vcoSourceSelect, .inductorSelect, .vcoRange,
    .loopFilterSelect, .chargePumpCurrent, .externalFilterBypass, .boostActive);
  radio_far_side_model i_far (.clk, .lpoFast, .lpoTrim, .lpoClkIn, .vcoRange, .vcoAboveTarget);

  always #50 clk = ~clk;

  task automatic results;
    if (n_fail == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 v = regRdData;
  endtask
  task automatic defaults;
    for (int i = 0; i < 11; i++) begin
      rd(dAddr[i], d);
      check(d, dVal[i]);
    end
  endtask
  task automatic run(input logic v, output int len);
    len = 0;
    while (sysClkOut === v && len < 5000) begin
      @(negedge clk);
      len++;
    end
  endtask
  task automatic measure;
    run(1'b1, n);
    run(1'b0, n);
    run(1'b1, hi);
    run(1'b0, lo);
  endtask
  task automatic ranging(input logic [7:0] a, input logic [31:0] f);
    wr(a, 32'h10);
    rd(a, d);
    check(32'(d[4]), 32'h1);
    check(carrierFreq, f);
    n = 0;
    while (d[4] !== 1'b0 && n < 500) begin
      rd(a, d);
      n++;
    end
    check(d, 32'h5);
    repeat (10) @(posedge clk);
  endtask

  initial begin
    #10_000_000;
    n_fail++;
    results();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    defaults();
    measure();
    check(32'(hi), 32'h8);
    check(32'(lo), 32'h8);
    for (int i = 0; i < 3; i++) begin
      wr(`ADDR_CLKOUT, 32'(sel[i]));
      repeat (1100) @(posedge clk);
      measure();
      check(32'(hi + lo * 2048), 32'(half[i] * 2049));
    end
    wr(`ADDR_CLKOUT, 32'h0);
    repeat (1100) @(posedge clk);
    #10 check(32'(sysClkOut), 32'h1);
    #50 check(32'(sysClkOut), 32'h0);
    wr(`ADDR_CLKOUT, 32'h24);
    // Oscillator handover needs a wrap with oscillator low
    repeat (21000) @(posedge clk);
    measure();
    check(32'(hi > 80 && hi < 130), 32'h1);
    wr(`ADDR_CLKOUT, 32'h44);
    repeat (21000) @(negedge clk);
    check(32'(sysClkOe), 32'h0);
    wr(`ADDR_PWR, 32'h0);
    repeat (2) @(negedge clk);
    check(32'(refOscEnable), 32'h0);
    wr(`ADDR_CARRIER_FREQ_SET_A, Carrier_freq_set_a);
    wr(`ADDR_LOOPN, 32'h2);
    wr(`ADDR_PWR, 32'h81);
    wr(`ADDR_PWR, 32'h01);
    defaults();
    wr(`ADDR_CARRIER_FREQ_SET_A, Carrier_freq_set_a);
    wr(`ADDR_CARRIER_FREQ_SET_B, Carrier_freq_set_b);
    wr(`ADDR_SYNTH, 32'h2);
    repeat (2) @(negedge clk);
    check(carrierFreq, Carrier_freq_set_b);
    wr(`ADDR_SYNTH, 32'h0);
    repeat (2) @(negedge clk);
    check(carrierFreq, Carrier_freq_set_a);
    wr(`ADDR_VCODIV, 32'h37);
    repeat (2) @(negedge clk);
    check(32'({refDivider, outputDividerBit, vcoSourceSelect, inductorSelect}), 32'h1f);
    ranging(`ADDR_RNGA, Carrier_freq_set_a);
    ranging(`ADDR_RNGB, Carrier_freq_set_b);
    check(32'(vcoRange), 32'h5);
    wr(`ADDR_VCODIV, 32'h10);
    wr(`ADDR_RNGA, 32'h10);
    rd(`ADDR_RNGA, d);
    check(d & 32'h30, 32'h20);
    for (int c = 0; c < 4; c++) begin
      wr(`ADDR_LOOPN, 32'(c));
      repeat (2) @(negedge clk);
      check(32'({externalFilterBypass, loopFilterSelect}), 32'({c == 0, 2'(c)}));
    end
    wr(`ADDR_LOOPN, 32'h1);
    wr(`ADDR_CPN, 32'h22);
    repeat (2) @(negedge clk);
    check(32'(chargePumpCurrent), 32'h22);
    wr(`ADDR_CPN, 32'h10);
    wr(`ADDR_BOOST, 32'h0001_0005);
    wr(`ADDR_SYNTH, 32'h1);
    @(negedge clk);
    n = 0;
    while (boostActive !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (boostActive === 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    check(32'(n), 32'h5);
    repeat (2) @(negedge clk);
    check(32'({loopFilterSelect, chargePumpCurrent}), 32'h110);
    wr(`ADDR_LPO, 32'h1);
    repeat (2) @(negedge clk);
    check(32'(lpoFast), 32'h1);
    wr(`ADDR_LPO, 32'h2);
    repeat (4000) @(posedge clk);
    rd(`ADDR_LPO, d);
    check(32'(d[2] && d[15:8] >= 8'h85 && d[15:8] <= 8'h87), 32'h1);
    check(32'(lpoTrim >= 8'h85 && lpoTrim <= 8'h87), 32'h1);
    results();
  end
endmodule

bind radio_clock_synth_control radio_clock_synth_control_properties i_props (.clk, .rst, .regRd, .regRdData,
  .lpoTrim, .sysClkOe, .refOscEnable, .vcoSourceSelect, .inductorSelect, .vcoRange, .loopFilterSelect,
  .chargePumpCurrent, .externalFilterBypass, .boostActive);
`default_nettype wire
